// >>> flash_pin_pkg.sv
// Package: constants shared by the serial flash pin interface design
package flash_pin_pkg;

    // ----------------------------------------------------------------
    // Array geometry
    // ----------------------------------------------------------------
    localparam int unsigned PAGE_COUNT      = 65536;
    localparam int unsigned PAGE_BYTES      = 256;
    localparam int unsigned PAGE_ADDR_W     = 16;
    localparam int unsigned BYTE_ADDR_W     = 24;
    localparam int unsigned PAGE_OFS_W      = 8;
    localparam logic [8:0]  PAGE_PROG_MAX   = 9'h100;
    localparam int unsigned SECTOR4K_LSB    = 12;
    localparam int unsigned BLOCK32K_LSB    = 15;
    localparam int unsigned BLOCK64K_LSB    = 16;

    // ----------------------------------------------------------------
    // Command opcodes carried over the link
    // ----------------------------------------------------------------
    localparam logic [7:0] OP_READ          = 8'h03;
    localparam logic [7:0] OP_READ_DUAL     = 8'h3B;
    localparam logic [7:0] OP_READ_QUAD     = 8'h6B;
    localparam logic [7:0] OP_PAGE_PROG     = 8'h02;
    localparam logic [7:0] OP_ERASE_4K      = 8'h20;
    localparam logic [7:0] OP_ERASE_32K     = 8'h52;
    localparam logic [7:0] OP_ERASE_64K     = 8'hD8;
    localparam logic [7:0] OP_ERASE_CHIP    = 8'hC7;
    localparam logic [7:0] OP_WRITE_STATUS  = 8'h01;

    localparam logic [5:0] OPCODE_BITS      = 6'h08;
    localparam logic [5:0] ADDR_END_BITS    = 6'h20;
    localparam logic [5:0] DUMMY_END_BITS   = 6'h28;

    // ----------------------------------------------------------------
    // Erase granularities handed to the core
    // ----------------------------------------------------------------
    typedef enum logic [2:0] {
        ERASE_NONE  = 3'h0,
        ERASE_4K    = 3'h1,
        ERASE_32K   = 3'h2,
        ERASE_64K   = 3'h3,
        ERASE_CHIP  = 3'h4
    } erase_kind_t;

    // ----------------------------------------------------------------
    // Link lane widths
    // ----------------------------------------------------------------
    typedef enum logic [2:0] {
        LANES_ONE   = 3'b001,
        LANES_TWO   = 3'b010,
        LANES_FOUR  = 3'b100
    } lane_mode_t;

endpackage

// >>> flash_link_if.sv
// Interface: events carried from the link clock domain to the core clock domain
`timescale 1ns/1ps
interface flash_link_if;
    logic [7:0]  cmd_op;       // Opcode of the completed command
    logic [23:0] cmd_addr;     // Address of the completed command
    logic [8:0]  cmd_bytes;    // Data bytes taken, capped at one page
    logic        sel_seen;     // Level: a select fall has been seen

    modport link (output cmd_op, output cmd_addr, output cmd_bytes, output sel_seen);
    modport core (input cmd_op, input cmd_addr, input cmd_bytes, input sel_seen);
endinterface

// >>> flash_link_shifter.sv
// Module: link-clock side shifter for the serial flash pins
`timescale 1ns/1ps
module flash_link_shifter (
    input  wire logic        sck,          // Serial clock from host
    input  wire logic        cs_b,         // Select, active low, async clear
    input  wire logic        quad_ok,      // Quad lanes permitted
    input  wire logic [7:0]  rd_data,      // Byte to return on reads
    input  wire logic [3:0]  io_in,        // Lane inputs
    output logic      [3:0]  io_out,       // Lane outputs
    output logic      [3:0]  io_oe,        // Lane enables
    flash_link_if.link       lnk           // Events toward core
);
    logic [5:0]  cnt_q, cnt_d;
    logic [7:0]  op_q, op_d;
    logic [23:0] addr_q, addr_d;
    logic [8:0]  bytes_q, bytes_d;
    logic [2:0]  bit_q, bit_d;
    logic [2:0]  fcnt_q, fcnt_d;
    logic        seen_q;
    logic [7:0]  sh_q, sh_d;
    logic [3:0]  out_q, out_d;
    logic [3:0]  oe_q, oe_d;
    flash_pin_pkg::lane_mode_t mode;
    logic        rd_cmd, in_data;

    // ----------------------------------------------------------------
    // Rising edge: sample command and address, count data bytes
    // ----------------------------------------------------------------
    always_comb begin
        cnt_d   = cnt_q;
        op_d    = op_q;
        addr_d  = addr_q;
        bytes_d = bytes_q;
        bit_d   = bit_q;
        if (cnt_q < flash_pin_pkg::OPCODE_BITS) begin
            op_d  = {op_q[6:0], io_in[0]};
            cnt_d = cnt_q + 6'h01;
        end else if (cnt_q < flash_pin_pkg::ADDR_END_BITS) begin
            addr_d = {addr_q[22:0], io_in[0]};
            cnt_d  = cnt_q + 6'h01;
        end else if (op_q == flash_pin_pkg::OP_PAGE_PROG) begin
            bit_d = bit_q + 3'h1;
            if (bit_q == 3'h7 && bytes_q < flash_pin_pkg::PAGE_PROG_MAX) begin
                bytes_d = bytes_q + 9'h001;
            end
        end else if (cnt_q < flash_pin_pkg::DUMMY_END_BITS) begin
            cnt_d = cnt_q + 6'h01;
        end
    end

    // Select high clears the whole front end, so stray SI levels never count
    always_ff @(posedge sck or posedge cs_b) begin
        if (cs_b) begin
            cnt_q   <= 6'h00;
            op_q    <= 8'h00;
            addr_q  <= 24'h000000;
            bytes_q <= 9'h000;
            bit_q   <= 3'h0;
        end else begin
            cnt_q   <= cnt_d;
            op_q    <= op_d;
            addr_q  <= addr_d;
            bytes_q <= bytes_d;
            bit_q   <= bit_d;
        end
    end

    // ----------------------------------------------------------------
    // End of frame: catch the fields before select clears them
    // ----------------------------------------------------------------
    always_ff @(posedge cs_b) begin
        lnk.cmd_op    <= op_q;
        lnk.cmd_addr  <= addr_q;
        lnk.cmd_bytes <= bytes_q;
    end

    // Any select fall arms the core; sticky level crossed by two flops
    always_ff @(negedge cs_b) begin
        seen_q <= 1'b1;
    end

    // ----------------------------------------------------------------
    // Falling edge: launch read data on one, two or four lanes
    // ----------------------------------------------------------------
    assign rd_cmd  = (op_q == flash_pin_pkg::OP_READ) || (op_q == flash_pin_pkg::OP_READ_DUAL)
                     || (op_q == flash_pin_pkg::OP_READ_QUAD);
    assign in_data = (op_q == flash_pin_pkg::OP_READ) ? (cnt_q >= flash_pin_pkg::ADDR_END_BITS)
                     : (cnt_q >= flash_pin_pkg::DUMMY_END_BITS);

    always_comb begin
        if (op_q == flash_pin_pkg::OP_READ_QUAD && quad_ok) begin
            mode = flash_pin_pkg::LANES_FOUR;
        end else if (op_q == flash_pin_pkg::OP_READ_DUAL) begin
            mode = flash_pin_pkg::LANES_TWO;
        end else begin
            mode = flash_pin_pkg::LANES_ONE;
        end
    end

    always_comb begin
        sh_d  = sh_q;
        out_d = 4'h0;
        oe_d  = 4'h0;
        fcnt_d = 3'h0;
        if (rd_cmd && in_data) begin
            fcnt_d = fcnt_q + mode; // One-hot lane code is bits per edge
            unique case (mode)
                flash_pin_pkg::LANES_FOUR: begin
                    out_d = sh_q[7:4];
                    sh_d  = {sh_q[3:0], 4'h0};
                    oe_d  = 4'hF;
                end
                flash_pin_pkg::LANES_TWO: begin
                    out_d = {2'h0, sh_q[7:6]};
                    sh_d  = {sh_q[5:0], 2'h0};
                    oe_d  = 4'h3;
                end
                flash_pin_pkg::LANES_ONE: begin
                    out_d = {2'h0, sh_q[7], 1'b0};
                    sh_d  = {sh_q[6:0], 1'b0};
                    oe_d  = 4'h2;
                end
            endcase
            if (fcnt_d == 3'h0) begin
                sh_d = rd_data;
            end
        end else begin
            sh_d = rd_data;
        end
    end

    always_ff @(negedge sck or posedge cs_b) begin
        if (cs_b) begin
            sh_q  <= 8'h00;
            fcnt_q <= 3'h0;
            out_q <= 4'h0;
            oe_q  <= 4'h0;
        end else begin
            sh_q  <= sh_d;
            fcnt_q <= fcnt_d;
            out_q <= out_d;
            oe_q  <= oe_d;
        end
    end

    assign io_out        = out_q;
    assign io_oe         = oe_q & {4{~cs_b}};
    assign lnk.sel_seen  = seen_q;
endmodule // flash_link_shifter

// >>> serial_flash_pin_interface.sv
// Module: top of the serial flash pin interface, core clock domain
`timescale 1ns/1ps

// Functional notes
// - Select high: deselected, outputs high impedance
// - Deselected means standby unless busy cycle
// - No command before first select fall
// - Inputs sampled on rising serial clock
// - Outputs launched on falling serial clock
// - Dual/quad reads turn input into lane zero
// - Input ignored while select high
// - Dual read: output line carries lane one
// - Protect pin low blocks status writes when status lock bits are set
// - Quad enable turns protect pin into lane
// - 65536 pages of 256 bytes, page cap
// - Erase 4K, 32K, 64K or whole chip
module serial_flash_pin_interface (
    input  wire logic        clock,                 // Core clock, 125 MHz
    input  wire logic        rst_b,                 // Async reset, active low
    input  wire logic        sck,                   // Serial clock from host
    input  wire logic        cs_b,                  // Select, active low
    input  wire logic [3:0]  io_in,                 // Lane inputs, lane 2 is protect pin
    output logic      [3:0]  io_out,                // Lane outputs
    output logic      [3:0]  io_oe,                 // Lane output enables
    input  wire logic        quad_lane_enable_bit,  // Quad enable from status
    input  wire logic [1:0]  status_lock_bits,      // Status protect bits
    input  wire logic        busy_in,               // Internal cycle running
    input  wire logic [7:0]  rd_data,               // Read byte for the link
    output logic             cmd_valid_q,           // Pulse: command accepted
    output logic      [7:0]  cmd_op_q,              // Accepted opcode
    output logic      [15:0] cmd_page_q,            // Page index
    output logic      [7:0]  cmd_offset_q,          // Byte within page
    output logic      [8:0]  cmd_bytes_q,           // Program byte count
    output flash_pin_pkg::erase_kind_t erase_kind_q, // Erase granularity
    output logic             status_write_q,        // Pulse: status write allowed
    output logic             status_blocked_q,      // Pulse: status write refused
    output logic             array_protect_q,       // Level: hardware protect active
    output logic             standby_q,             // Level: standby power mode
    output logic             selected_q             // Level: device selected
);
    flash_link_if lnk ();
    logic [3:0] sh_out, sh_oe;
    logic       quad_ok_q;

    // ----------------------------------------------------------------
    // Link side
    // ----------------------------------------------------------------
    flash_link_shifter u_shift (
        .sck     (sck),
        .cs_b    (cs_b),
        .quad_ok (quad_ok_q),
        .rd_data (rd_data),
        .io_in   (io_in),
        .io_out  (sh_out),
        .io_oe   (sh_oe),
        .lnk     (lnk)
    );

    // Lane outputs are launched by sck flops; quiet when select is high
    assign io_out = sh_out;
    assign io_oe  = sh_oe;

    // ----------------------------------------------------------------
    // Synchronisers into the core domain
    // ----------------------------------------------------------------
    logic [1:0] cs_sync_q, seen_sync_q, wp_sync_q;
    logic       cs_last_q;

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            cs_sync_q   <= 2'h3;
            seen_sync_q <= 2'h0;
            wp_sync_q   <= 2'h3;
            cs_last_q   <= 1'b1;
        end else begin
            cs_sync_q   <= {cs_sync_q[0], cs_b};
            seen_sync_q <= {seen_sync_q[0], lnk.sel_seen};
            wp_sync_q   <= {wp_sync_q[0], io_in[2]};
            cs_last_q   <= cs_sync_q[1];
        end
    end

    logic cmd_done, wp_low, armed;
    assign cmd_done = cs_sync_q[1] & ~cs_last_q;
    // Quad enable hands the protect pin over to data lane two
    assign wp_low   = ~wp_sync_q[1] & ~quad_lane_enable_bit;
    // Seen flop powers up unknown; armed only after a seen fall
    assign armed    = seen_sync_q[1] === 1'b1;

    // ----------------------------------------------------------------
    // Command decode, core domain
    // ----------------------------------------------------------------
    logic                       valid_d, sw_d, sb_d, prot_d, stby_d, sel_d, quad_d;
    logic [7:0]                 op_d, ofs_d;
    logic [15:0]                page_d;
    logic [8:0]                 bytes_d;
    flash_pin_pkg::erase_kind_t erase_d;

    always_comb begin
        valid_d = 1'b0;
        sw_d    = 1'b0;
        sb_d    = 1'b0;
        op_d    = cmd_op_q;
        page_d  = cmd_page_q;
        ofs_d   = cmd_offset_q;
        bytes_d = cmd_bytes_q;
        erase_d = flash_pin_pkg::ERASE_NONE;
        sel_d   = ~cs_sync_q[1];
        stby_d  = cs_sync_q[1] & ~busy_in;
        quad_d  = quad_lane_enable_bit;
        prot_d  = wp_low & (status_lock_bits != 2'h0);
        if (cmd_done && armed) begin
            valid_d = 1'b1;
            op_d    = lnk.cmd_op;
            page_d  = lnk.cmd_addr[flash_pin_pkg::BYTE_ADDR_W-1:flash_pin_pkg::PAGE_OFS_W];
            ofs_d   = lnk.cmd_addr[flash_pin_pkg::PAGE_OFS_W-1:0];
            bytes_d = lnk.cmd_bytes;
            unique case (lnk.cmd_op)
                flash_pin_pkg::OP_ERASE_4K:   erase_d = flash_pin_pkg::ERASE_4K;
                flash_pin_pkg::OP_ERASE_32K:  erase_d = flash_pin_pkg::ERASE_32K;
                flash_pin_pkg::OP_ERASE_64K:  erase_d = flash_pin_pkg::ERASE_64K;
                flash_pin_pkg::OP_ERASE_CHIP: erase_d = flash_pin_pkg::ERASE_CHIP;
                default:                      erase_d = flash_pin_pkg::ERASE_NONE;
            endcase
            if (lnk.cmd_op == flash_pin_pkg::OP_WRITE_STATUS) begin
                sw_d = ~prot_d;
                sb_d = prot_d;
            end
        end
    end

    // Command fields are caught at the select rise, two synced edges before use
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            cmd_valid_q      <= 1'b0;
            cmd_op_q         <= 8'h00;
            cmd_page_q       <= 16'h0000;
            cmd_offset_q     <= 8'h00;
            cmd_bytes_q      <= 9'h000;
            erase_kind_q     <= flash_pin_pkg::ERASE_NONE;
            status_write_q   <= 1'b0;
            status_blocked_q <= 1'b0;
            array_protect_q  <= 1'b0;
            standby_q        <= 1'b1;
            selected_q       <= 1'b0;
            quad_ok_q        <= 1'b0;
        end else begin
            cmd_valid_q      <= valid_d;
            cmd_op_q         <= op_d;
            cmd_page_q       <= page_d;
            cmd_offset_q     <= ofs_d;
            cmd_bytes_q      <= bytes_d;
            erase_kind_q     <= erase_d;
            status_write_q   <= sw_d;
            status_blocked_q <= sb_d;
            array_protect_q  <= prot_d;
            standby_q        <= stby_d;
            selected_q       <= sel_d;
            quad_ok_q        <= quad_d;
        end
    end
endmodule // serial_flash_pin_interface

// >>> serial_flash_pin_interface_chk.sv
// Checker: port-level assertions for the serial flash pin interface
`timescale 1ns/1ps
module serial_flash_pin_interface_chk (
    input wire logic                       clock,                // Core clock
    input wire logic                       rst_b,                // Reset, active low
    input wire logic                       cs_b,                 // Select, active low
    input wire logic [3:0]                 io_in,                // Lane inputs
    input wire logic [3:0]                 io_oe,                // Lane enables
    input wire logic                       quad_lane_enable_bit, // Quad enable
    input wire logic [1:0]                 status_lock_bits,     // Status protect bits
    input wire logic                       busy_in,              // Internal cycle running
    input wire logic                       cmd_valid_q,          // Command pulse
    input wire logic [7:0]                 cmd_op_q,             // Opcode
    input wire logic [8:0]                 cmd_bytes_q,          // Program byte count
    input wire flash_pin_pkg::erase_kind_t erase_kind_q,         // Erase kind
    input wire logic                       status_write_q,       // Status write allowed
    input wire logic                       status_blocked_q,     // Status write refused
    input wire logic                       array_protect_q,      // Hardware protect
    input wire logic                       standby_q             // Standby mode
);
    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_b);
    logic prot;  // Protect conditions present at the pins
    assign prot = !io_in[2] && !quad_lane_enable_bit && (status_lock_bits != 2'h0);
    function automatic logic [2:0] kind_of(input logic [7:0] op);
        case (op)
            flash_pin_pkg::OP_ERASE_4K:   kind_of = 3'h1;
            flash_pin_pkg::OP_ERASE_32K:  kind_of = 3'h2;
            flash_pin_pkg::OP_ERASE_64K:  kind_of = 3'h3;
            flash_pin_pkg::OP_ERASE_CHIP: kind_of = 3'h4;
            default:                      kind_of = 3'h0;
        endcase
    endfunction
    // ------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------
    property p_oe_off; cs_b |-> io_oe == 4'h0; endproperty
    a_oe_off: assert property (p_oe_off) else $error("lanes driven while deselected");
    property p_standby; (cs_b && !busy_in)[*5] |-> standby_q; endproperty
    a_standby: assert property (p_standby) else $error("no standby when idle");
    property p_busy; busy_in[*2] |-> !standby_q; endproperty
    a_busy: assert property (p_busy) else $error("standby during busy cycle");
    property p_status_pair;
        cmd_valid_q && cmd_op_q == flash_pin_pkg::OP_WRITE_STATUS
            |-> status_blocked_q == array_protect_q && status_write_q != array_protect_q;
    endproperty
    a_status_pair: assert property (p_status_pair) else $error("status write outcome wrong");
    property p_status_src;
        status_write_q || status_blocked_q |-> cmd_valid_q && cmd_op_q == flash_pin_pkg::OP_WRITE_STATUS;
    endproperty
    a_status_src: assert property (p_status_src) else $error("stray status pulse");
    property p_protect_on; prot[*5] |-> array_protect_q; endproperty
    a_protect_on: assert property (p_protect_on) else $error("protect missing");
    property p_protect_off; (!prot)[*5] |-> !array_protect_q; endproperty
    a_protect_off: assert property (p_protect_off) else $error("protect without cause");
    property p_bytes_cap; cmd_valid_q |-> cmd_bytes_q <= flash_pin_pkg::PAGE_PROG_MAX; endproperty
    a_bytes_cap: assert property (p_bytes_cap) else $error("byte count over a page");
    property p_erase_kind; cmd_valid_q |-> erase_kind_q == kind_of(cmd_op_q); endproperty
    a_erase_kind: assert property (p_erase_kind) else $error("erase kind mismatch");
    property p_quad_lanes; !quad_lane_enable_bit |-> io_oe[3:2] == 2'h0; endproperty
    a_quad_lanes: assert property (p_quad_lanes) else $error("upper lanes without quad");
    property p_valid_desel; cmd_valid_q |-> cs_b; endproperty
    a_valid_desel: assert property (p_valid_desel) else $error("command before frame end");
    c_full_page: cover property (cmd_valid_q && cmd_bytes_q == flash_pin_pkg::PAGE_PROG_MAX);
    c_blocked: cover property (status_blocked_q);
    c_quad: cover property (io_oe == 4'hF);
endmodule // serial_flash_pin_interface_chk

bind serial_flash_pin_interface serial_flash_pin_interface_chk serial_flash_pin_interface_chk_inst (
    .clock(clock), .rst_b(rst_b), .cs_b(cs_b), .io_in(io_in), .io_oe(io_oe),
    .quad_lane_enable_bit(quad_lane_enable_bit), .status_lock_bits(status_lock_bits), .busy_in(busy_in),
    .cmd_valid_q(cmd_valid_q), .cmd_op_q(cmd_op_q), .cmd_bytes_q(cmd_bytes_q), .erase_kind_q(erase_kind_q),
    .status_write_q(status_write_q), .status_blocked_q(status_blocked_q), .array_protect_q(array_protect_q),
    .standby_q(standby_q));

// >>> spi_host_model.sv
// Partner: behavioural host controller that drives the serial flash pins
`timescale 1ns/1ps
module spi_host_model (
    input  wire logic       wp_b,    // Protect level shown on lane 2
    input  wire logic [3:0] lanes,   // Resolved lane levels
    output logic            sck,     // Serial clock, idle low
    output logic            cs_b,    // Select, active low
    output logic      [3:0] host_o,  // Host lane values
    output logic      [3:0] host_oe  // Host lane enables
);
    logic [7:0] rd_got[$];  // Bytes read in the last frame
    logic       si;
    logic [3:0] rel;
    // Lane 3 is the hold pin and is kept high except in quad reads, which release it; lane 1 is never driven by the host
    assign host_o = {1'b1, wp_b, 1'b0, si};
    assign host_oe = ~rel & 4'hD;
    initial begin
        sck = 1'b0;
        cs_b = 1'b1;
        si = 1'b0;
        rel = 4'h0;
    end
    task automatic clk_bit(input logic v);
        si = v;
        #16 sck = 1'b1;
        #16 sck = 1'b0;
    endtask
    // Clocking while deselected, used only to show that the pins are ignored
    task automatic noise(input int n);
        for (int i = 0; i < n; i++) clk_bit(1'($urandom));
    endtask
    task automatic frame(input logic [7:0] op, input logic [23:0] addr, input int nprog, input int nread,
                         input int nl);
        logic [31:0] hdr;
        logic [7:0]  b;
        hdr = {op, addr};
        rd_got.delete();
        cs_b = 1'b0;
        #8;
        for (int i = 31; i >= 0; i--) clk_bit(hdr[i]);
        for (int i = 0; i < nprog * 8; i++) clk_bit(1'($urandom));
        if (nl > 1) rel = (nl == 4) ? 4'hD : 4'h1;
        if (op != flash_pin_pkg::OP_READ && nread > 0) for (int i = 0; i < 8; i++) clk_bit(1'b0);
        for (int k = 0; k < nread; k++) begin
            for (int i = 0; i < 8; i += nl) begin
                #16 sck = 1'b1;
                b = (nl == 4) ? {b[3:0], lanes} : (nl == 2) ? {b[5:0], lanes[1:0]} : {b[6:0], lanes[1]};
                #16 sck = 1'b0;
            end
            rd_got.push_back(b);
        end
        cs_b = 1'b1;
        rel = 4'h0;
    endtask
endmodule // spi_host_model

// >>> serial_flash_pin_interface_test.sv
// Testbench: self-checking bench for the serial flash pin interface
`timescale 1ns/1ps
module serial_flash_pin_interface_test;
    typedef struct packed {logic [7:0] op; logic [23:0] addr; logic [8:0] nb; logic [2:0] kind; logic [1:0] st;} note_t;
    localparam logic [7:0] ERASE_OPS [4] = '{flash_pin_pkg::OP_ERASE_4K, flash_pin_pkg::OP_ERASE_32K,
                                             flash_pin_pkg::OP_ERASE_64K, flash_pin_pkg::OP_ERASE_CHIP};
    logic clock, rst_b, sck, cs_b, quad, busy_in, wp_b, cmd_valid_q, status_write_q, status_blocked_q;
    logic array_protect_q, standby_q, selected_q;
    logic flip = 1'b0;
    logic [3:0] io_in, io_out, io_oe, host_o, host_oe;
    logic [1:0] lock;
    logic [7:0] rd_data, cmd_op_q, cmd_offset_q;
    logic [15:0] cmd_page_q;
    logic [8:0] cmd_bytes_q;
    flash_pin_pkg::erase_kind_t erase_kind_q;
    note_t notes[$];
    note_t m;
    int bad_count = 0;
    int compares = 0;
    // Released lanes carry a changing pattern so a stale value never passes
    assign io_in = (io_oe & io_out) | (~io_oe & host_oe & host_o) | (~io_oe & ~host_oe & {4{flip}});
    always @(posedge clock) flip <= ~flip;
    initial begin
        clock = 1'b0;
        forever #4 clock = ~clock;
    end
    serial_flash_pin_interface serial_flash_pin_interface_inst (
        .clock(clock), .rst_b(rst_b), .sck(sck), .cs_b(cs_b), .io_in(io_in), .io_out(io_out), .io_oe(io_oe),
        .quad_lane_enable_bit(quad), .status_lock_bits(lock), .busy_in(busy_in), .rd_data(rd_data),
        .cmd_valid_q(cmd_valid_q), .cmd_op_q(cmd_op_q), .cmd_page_q(cmd_page_q), .cmd_offset_q(cmd_offset_q),
        .cmd_bytes_q(cmd_bytes_q), .erase_kind_q(erase_kind_q), .status_write_q(status_write_q),
        .status_blocked_q(status_blocked_q), .array_protect_q(array_protect_q), .standby_q(standby_q),
        .selected_q(selected_q));
    spi_host_model spi_host_model_inst (
        .wp_b(wp_b), .lanes(io_in), .sck(sck), .cs_b(cs_b), .host_o(host_o), .host_oe(host_oe));
    // ------------------------------------------------------------
    // Comparison, verdict and watchdog
    // ------------------------------------------------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
        compares++;
        if (seen !== exp) begin
            bad_count++;
            $display("CHECK FAILED at %0t: %s", $time, msg);
        end
    endtask
    task automatic results();
        $display("compares %0d, mismatches %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    initial begin
        #600000;
        bad_count++;
        results();
    end
    // Monitor: every reported command must match the oldest note
    always @(negedge clock) begin
        if (rst_b === 1'b1 && cmd_valid_q !== 1'b0) begin
            if (notes.size() == 0) check(32'h1, 32'h0, "unexpected command");
            else begin
                m = notes.pop_front();
                check({cmd_op_q, cmd_page_q, cmd_offset_q}, {m.op, m.addr}, "command fields");
                if (m.op == flash_pin_pkg::OP_PAGE_PROG) check(cmd_bytes_q, m.nb, "byte count");
                check(erase_kind_q, m.kind, "erase kind");
                check({status_write_q, status_blocked_q}, m.st, "status write outcome");
            end
        end
    end
    // ------------------------------------------------------------
    // Stimulus
    // ------------------------------------------------------------
    task automatic run(input logic [7:0] op, input int nprog, input int nread, input int nl, input logic [2:0] k);
        note_t n;
        logic  sb;
        repeat (6) @(negedge clock);
        rd_data = 8'($urandom);
        sb = !wp_b && !quad && lock != 2'h0;
        n.op = op;
        n.addr = 24'($urandom);
        n.nb = (nprog > 256) ? 9'h100 : 9'(nprog);
        n.kind = k;
        n.st = (op == flash_pin_pkg::OP_WRITE_STATUS) ? {!sb, sb} : 2'h0;
        notes.push_back(n);
        #3;
        spi_host_model_inst.frame(op, n.addr, nprog, nread, nl);
        check(selected_q, 1'b1, "not selected in frame");
        check(32'(spi_host_model_inst.rd_got.size()), 32'(nread), "read length");
        foreach (spi_host_model_inst.rd_got[i]) check(spi_host_model_inst.rd_got[i], rd_data, "read byte");
        repeat (12) @(negedge clock);
    endtask
    initial begin
        void'($urandom(32'hFB9E1B6E));
        rst_b = 1'b0;
        quad = 1'b0;
        lock = 2'h0;
        busy_in = 1'b0;
        wp_b = 1'b1;
        rd_data = 8'h00;
        repeat (8) @(negedge clock);
        rst_b = 1'b1;
        repeat (4) @(negedge clock);
        spi_host_model_inst.noise(40);
        run(flash_pin_pkg::OP_READ, 0, 2, 1, 3'h0);
        run(flash_pin_pkg::OP_READ_DUAL, 0, 2, 2, 3'h0);
        quad = 1'b1;
        run(flash_pin_pkg::OP_READ_QUAD, 0, 2, 4, 3'h0);
        quad = 1'b0;
        run(flash_pin_pkg::OP_READ_QUAD, 0, 2, 1, 3'h0);
        run(flash_pin_pkg::OP_PAGE_PROG, 1, 0, 1, 3'h0);
        run(flash_pin_pkg::OP_PAGE_PROG, 256, 0, 1, 3'h0);
        run(flash_pin_pkg::OP_PAGE_PROG, 257, 0, 1, 3'h0);
        for (int k = 0; k < 4; k++) run(ERASE_OPS[k], 0, 0, 1, 3'(k + 1));
        for (int c = 0; c < 8; c++) begin
            wp_b = c[0];
            quad = c[1];
            lock = c[2] ? 2'(1 + $urandom_range(2)) : 2'h0;
            run(flash_pin_pkg::OP_WRITE_STATUS, 1, 0, 1, 3'h0);
        end
        busy_in = 1'b1;
        repeat (6) @(negedge clock);
        check(standby_q, 1'b0, "standby while busy");
        busy_in = 1'b0;
        repeat (6) @(negedge clock);
        check(standby_q, 1'b1, "standby when idle");
        check(32'(notes.size()), 32'h0, "command not reported");
        results();
    end
endmodule // serial_flash_pin_interface_test
